// file: gcgm_top.sv
// global clock buffer element: plain buffer, clock gate or glitchless clock mux
// Functional notes
// RULE_01: enable high before a rising edge passes the whole following clock pulse.
// RULE_02: enable low before a rising edge suppresses that pulse, output held low.
// RULE_03: enable changes while the input clock is high do not affect that pulse.
// RULE_04: select low routes the first clock input, select high the second.
// RULE_05: no output high or low phase shorter than either input's shortest phase.
// RULE_06: while the selected clock is high, select changes are ignored.
// RULE_07: after select change and current low, output low until new clock falls.
// RULE_08: gate and mux both offer rising-edge and falling-edge modes by configuration.
// RULE_09: falling mode swaps rising/falling and high/low; enable and select levels unchanged.
// RULE_10: each input driven by pad, clock manager or fabric, fixed by configuration.
// RULE_11: distribution branches without loads stay static instead of toggling.
// RULE_12: the user design uses at most eight global clocks per quadrant.
// RULE_13: drivers of enable or select change them only while the clock is high.
`timescale 1ns/1ns
module gcgm_top
    import gcgm_pkg::*;
#(
    parameter int BRANCHES = GCGM_BRANCHES
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 firstPadClk,
    input  wire logic                 firstMgrClk,
    input  wire logic                 firstFabClk,
    input  wire logic                 secondPadClk,
    input  wire logic                 secondMgrClk,
    input  wire logic                 secondFabClk,
    input  wire gcgm_pkg::gcgm_src_e  firstSrcCfg,
    input  wire gcgm_pkg::gcgm_src_e  secondSrcCfg,
    input  wire gcgm_pkg::gcgm_mode_e modeCfg,
    input  wire logic                 fallingEdgeCfg,
    input  wire logic                 gateEnable,
    input  wire logic                 muxSelect,
    input  wire logic [BRANCHES-1:0]  branchLoaded,
    output logic                      clkOut,
    output logic [BRANCHES-1:0]       branchClk,
    output logic                      muxSecondActive,
    output logic                      muxSwitching
);

    logic                first_clock_in;
    logic                second_clock_in;
    logic                lvl0Prev_ff;
    logic                lvl1Prev_ff;
    logic                enPrev_ff;
    logic                pass_ff;
    logic                cur_ff;
    gcgm_mux_e           state_ff;
    logic                clkOut_ff;
    logic [BRANCHES-1:0] branchClk_ff;
    logic                nxt_pass;
    logic                nxt_cur;
    gcgm_mux_e           nxt_state;
    logic                nxt_norm;

    gcgm_src_sel u_src_first (
        .padClk (firstPadClk),
        .mgrClk (firstMgrClk),
        .fabClk (firstFabClk),
        .srcCfg (firstSrcCfg),
        .selClk (first_clock_in)
    );

    gcgm_src_sel u_src_second (
        .padClk (secondPadClk),
        .mgrClk (secondMgrClk),
        .fabClk (secondFabClk),
        .srcCfg (secondSrcCfg),
        .selClk (second_clock_in)
    );

    // single point where the configured polarity is put back on the output side
    function automatic logic restorePol(input logic normLvl, input logic fallMode);
        return normLvl ^ fallMode;
    endfunction : restorePol

    // limitation: input clocks are seen only at clk edges, so every input phase
    // must last at least one clk period or whole pulses can be missed

    // RULE_09 normalise polarity
    // in falling mode the clocks are inverted so the rest works on "active high" phases;
    // enable and select are never inverted
    wire lvl0     = first_clock_in ^ fallingEdgeCfg;
    wire lvl1     = second_clock_in ^ fallingEdgeCfg;
    wire rise0    = lvl0 & ~lvl0Prev_ff;
    wire isGate   = (modeCfg == GCGM_MODE_GATE);
    wire isMux    = (modeCfg == GCGM_MODE_MUX);
    wire isBuffer = (modeCfg == GCGM_MODE_BUFFER);

    // RULE_04 select picks the clock
    // mux views relative to the clock currently driving the output
    wire curLvl     = cur_ff ? lvl1 : lvl0;
    wire curPrev    = cur_ff ? lvl1Prev_ff : lvl0Prev_ff;
    wire newLvl     = cur_ff ? lvl0 : lvl1;
    wire newPrev    = cur_ff ? lvl0Prev_ff : lvl1Prev_ff;
    wire newFall    = newPrev & ~newLvl;
    wire wantSwitch = (muxSelect != cur_ff);
    wire outNorm    = clkOut_ff ^ fallingEdgeCfg;

    // RULE_01 pass decision at edge
    // the enable is taken one sample before the rising edge, so a late change
    // inside the setup window cannot cut the pulse
    assign nxt_pass = rise0 ? enPrev_ff : pass_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_cur   = cur_ff;
        case (state_ff)
            GCGM_MUX_FOLLOW: begin
                // RULE_06 ignore select while high
                if (isMux && wantSwitch && !curLvl) begin
                    nxt_state = GCGM_MUX_HOLD;
                end
            end
            GCGM_MUX_HOLD: begin
                // RULE_07 wait for new clock fall
                // a reverted select returns to the old clock only once it is low
                if (!wantSwitch && !curLvl) begin
                    nxt_state = GCGM_MUX_FOLLOW;
                end else if (wantSwitch && newFall) begin
                    nxt_state = GCGM_MUX_FOLLOW;
                    nxt_cur   = ~cur_ff;
                end
            end
            default: begin
                nxt_state = GCGM_MUX_FOLLOW;
            end
        endcase
    end

    always_comb begin
        case (modeCfg)
            GCGM_MODE_BUFFER: nxt_norm = lvl0;
            // RULE_02 suppressed pulse stays low
            GCGM_MODE_GATE:   nxt_norm = lvl0 & nxt_pass;
            // RULE_05 full phases only
            // output is low during hold and the new clock is joined on its fall,
            // so no phase seen is shorter than a complete phase of one input
            GCGM_MODE_MUX:    nxt_norm = (state_ff == GCGM_MUX_FOLLOW) ? curLvl : 1'b0;
            default:          nxt_norm = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lvl0Prev_ff <= GCGM_RST_LEVEL;
            lvl1Prev_ff <= GCGM_RST_LEVEL;
            enPrev_ff   <= GCGM_RST_ENABLE;
        end else begin
            lvl0Prev_ff <= lvl0;
            lvl1Prev_ff <= lvl1;
            enPrev_ff   <= gateEnable;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pass_ff  <= GCGM_RST_PASS;
            cur_ff   <= GCGM_RST_CUR;
            state_ff <= GCGM_MUX_FOLLOW;
        end else begin
            // RULE_03 pass latched only at rise
            pass_ff  <= nxt_pass;
            cur_ff   <= nxt_cur;
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clkOut_ff    <= GCGM_RST_LEVEL;
            branchClk_ff <= '0;
        end else begin
            // RULE_08 polarity restored on output
            clkOut_ff    <= restorePol(nxt_norm, fallingEdgeCfg);
            // RULE_11 unloaded branches static
            branchClk_ff <= branchLoaded & {BRANCHES{restorePol(nxt_norm, fallingEdgeCfg)}};
        end
    end

    assign clkOut          = clkOut_ff;
    assign branchClk       = branchClk_ff;
    assign muxSecondActive = cur_ff;
    assign muxSwitching    = (state_ff == GCGM_MUX_HOLD);

    a_gate_pass_pulse: assert property ( // RULE_01
        @(posedge clk) disable iff (!rstn)
        isGate && rise0 && enPrev_ff |=> outNorm
    ) else $error("gated pulse not passed");

    a_gate_block_pulse: assert property ( // RULE_02
        @(posedge clk) disable iff (!rstn)
        isGate && rise0 && !enPrev_ff |=> !outNorm
    ) else $error("gated pulse not suppressed");

    a_gate_high_stable: assert property ( // RULE_03
        @(posedge clk) disable iff (!rstn)
        isGate && lvl0 && lvl0Prev_ff |=> $stable(pass_ff)
    ) else $error("pass decision changed while clock high");

    a_mux_route_sel: assert property ( // RULE_04
        @(posedge clk) disable iff (!rstn)
        isMux && state_ff == GCGM_MUX_FOLLOW ##1 $stable(fallingEdgeCfg)
        |-> outNorm == ($past(cur_ff) ? $past(lvl1) : $past(lvl0))
    ) else $error("mux output does not follow selected clock");

    a_mux_ignore_high: assert property ( // RULE_06
        @(posedge clk) disable iff (!rstn)
        isMux && state_ff == GCGM_MUX_FOLLOW && curLvl
        |=> state_ff == GCGM_MUX_FOLLOW && $stable(cur_ff)
    ) else $error("select acted while current clock high");

    a_mux_hold_low: assert property ( // RULE_07
        @(posedge clk) disable iff (!rstn)
        isMux && state_ff == GCGM_MUX_HOLD ##1 $stable(fallingEdgeCfg) |-> !outNorm
    ) else $error("mux output not low during switchover");

    a_mux_switch_fall: assert property ( // RULE_07
        @(posedge clk) disable iff (!rstn)
        state_ff == GCGM_MUX_HOLD && wantSwitch && newFall
        |=> state_ff == GCGM_MUX_FOLLOW && cur_ff != $past(cur_ff)
    ) else $error("mux did not take new clock on its fall");

    a_buffer_polarity: assert property ( // RULE_08
        @(posedge clk) disable iff (!rstn)
        isBuffer |=> clkOut_ff == $past(first_clock_in)
    ) else $error("buffer output polarity wrong");

    a_branch_static: assert property ( // RULE_11
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> (branchClk_ff & ~$past(branchLoaded)) == '0
    ) else $error("unloaded branch toggles");

    a_gate_rise_take: assert property ( // RULE_01
        @(posedge clk) disable iff (!rstn)
        isGate && rise0 |=> pass_ff == $past(enPrev_ff)
    ) else $error("pass decision not taken from enable");

    a_gate_low_quiet: assert property ( // RULE_02
        @(posedge clk) disable iff (!rstn)
        isGate && !lvl0 |=> !outNorm
    ) else $error("gated output active while input low");

    // the output during a high phase depends only on the decision made at the rise
    a_gate_high_hold: assert property ( // RULE_03
        @(posedge clk) disable iff (!rstn)
        isGate && lvl0 && lvl0Prev_ff |=> outNorm == $past(pass_ff)
    ) else $error("enable change acted during high phase");

    a_mux_idle_follow: assert property ( // RULE_04
        @(posedge clk) disable iff (!rstn)
        !isMux && state_ff == GCGM_MUX_FOLLOW
        |=> state_ff == GCGM_MUX_FOLLOW && $stable(cur_ff)
    ) else $error("mux switched outside mux mode");

    // every output edge must coincide with an edge of the driving clock,
    // which keeps each output phase at least as long as an input phase
    a_mux_rise_edge: assert property ( // RULE_05
        @(posedge clk) disable iff (!rstn)
        isMux && $past(rstn) && !outNorm && nxt_norm
        |-> state_ff == GCGM_MUX_FOLLOW && curLvl && !curPrev
    ) else $error("mux output rose without a clock rise");

    a_mux_fall_edge: assert property ( // RULE_05
        @(posedge clk) disable iff (!rstn)
        isMux && $past(rstn) && outNorm && !nxt_norm
        |-> state_ff == GCGM_MUX_FOLLOW && !curLvl && curPrev
    ) else $error("mux output fell without a clock fall");

    a_mux_hold_enter: assert property ( // RULE_07
        @(posedge clk) disable iff (!rstn)
        isMux && state_ff == GCGM_MUX_FOLLOW && wantSwitch && !curLvl
        |=> state_ff == GCGM_MUX_HOLD
    ) else $error("mux did not hold after select change");

    a_mux_revert_low: assert property ( // RULE_07
        @(posedge clk) disable iff (!rstn)
        state_ff == GCGM_MUX_HOLD && !wantSwitch && !curLvl
        |=> state_ff == GCGM_MUX_FOLLOW && $stable(cur_ff)
    ) else $error("reverted select did not return to old clock");

    a_buffer_follow: assert property ( // RULE_09
        @(posedge clk) disable iff (!rstn)
        isBuffer |=> outNorm == $past(lvl0)
    ) else $error("buffer output does not follow normalised input");

    a_branch_copy: assert property ( // RULE_11
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> branchClk_ff == ($past(branchLoaded) & {BRANCHES{clkOut_ff}})
    ) else $error("loaded branch does not carry the output clock");

endmodule : gcgm_top

// file: gcgm_pkg.sv
// shared constants and types for the global clock gate and mux
package gcgm_pkg;

    // how the global buffer element is configured
    typedef enum logic [1:0] {
        GCGM_MODE_BUFFER,
        GCGM_MODE_GATE,
        GCGM_MODE_MUX
    } gcgm_mode_e;

    // where each buffer input takes its clock from
    typedef enum logic [1:0] {
        GCGM_SRC_PAD,
        GCGM_SRC_MANAGER,
        GCGM_SRC_FABRIC
    } gcgm_src_e;

    // switchover progress of the glitchless mux
    typedef enum logic {
        GCGM_MUX_FOLLOW,
        GCGM_MUX_HOLD
    } gcgm_mux_e;

    localparam int   GCGM_BRANCHES   = 8;
    localparam logic GCGM_RST_LEVEL  = 1'b0;
    localparam logic GCGM_RST_PASS   = 1'b0;
    localparam logic GCGM_RST_CUR    = 1'b0;
    localparam logic GCGM_RST_ENABLE = 1'b0;

endpackage : gcgm_pkg

// file: gcgm_src_sel.sv
// source selector for one global buffer input
`timescale 1ns/1ns
module gcgm_src_sel
    import gcgm_pkg::*;
(
    input  wire logic                padClk,
    input  wire logic                mgrClk,
    input  wire logic                fabClk,
    input  wire gcgm_pkg::gcgm_src_e srcCfg,
    output logic                     selClk
);

    wire isPad = (srcCfg == GCGM_SRC_PAD);
    wire isMgr = (srcCfg == GCGM_SRC_MANAGER);
    wire isFab = (srcCfg == GCGM_SRC_FABRIC);

    // RULE_10 configured source pick
    // an unused encoding drives a quiet low rather than any clock
    assign selClk = (isPad & padClk) | (isMgr & mgrClk) | (isFab & fabClk);

endmodule : gcgm_src_sel

// file: gcgm_clk_src.sv
// clock source model for the buffer inputs, stepped on the system clock
`timescale 1ns/1ns
module gcgm_clk_src #(
    parameter int HALF = 2
) (
    clk,
    lvl
);
    input  wire logic clk;
    output logic      lvl;
    int cnt = 0;
    initial lvl = 1'b0;
    // fixed half periods; two instances with coprime halves drift against each other
    always @(negedge clk) begin
        if (cnt == HALF - 1) begin
            lvl <= ~lvl;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : gcgm_clk_src

// file: gcgm_top_test.sv
// self-checking bench for the global clock gate and mux
`timescale 1ns/1ns
module gcgm_top_test;
    import gcgm_pkg::*;
    logic       clk = 0, rstn = 0, en = 0, sel = 0, f = 0;
    logic       ca, cb, clkOut, sAct, sSw, lastOut = 0;
    logic       expOut, expCur, expHold, pa, pb, enP, pass;
    logic [7:0] ld = 8'hff, bOut;
    gcgm_src_e  s1 = GCGM_SRC_PAD, s2 = GCGM_SRC_PAD;
    gcgm_mode_e md = GCGM_MODE_BUFFER;
    int         miscompares = 0, cmp_count = 0, runLen = 9;

    // only two global clocks in use, well inside the quadrant limit
    gcgm_clk_src #(.HALF(2)) srcA (.clk(clk), .lvl(ca));
    gcgm_clk_src #(.HALF(3)) srcB (.clk(clk), .lvl(cb));
    gcgm_top uut (.clk(clk), .rstn(rstn), .firstPadClk(ca), .firstMgrClk(cb),
        .firstFabClk(~ca), .secondPadClk(cb), .secondMgrClk(ca), .secondFabClk(~cb),
        .firstSrcCfg(s1), .secondSrcCfg(s2), .modeCfg(md), .fallingEdgeCfg(f),
        .gateEnable(en), .muxSelect(sel), .branchLoaded(ld), .clkOut(clkOut),
        .branchClk(bOut), .muxSecondActive(sAct), .muxSwitching(sSw));

    // unused source code reads as a stopped, low clock
    wire a = (s1 == GCGM_SRC_PAD ? ca : s1 == GCGM_SRC_MANAGER ? cb
             : s1 == GCGM_SRC_FABRIC ? ~ca : 1'b0) ^ f;
    wire b = (s2 == GCGM_SRC_PAD ? cb : s2 == GCGM_SRC_MANAGER ? ca
             : s2 == GCGM_SRC_FABRIC ? ~cb : 1'b0) ^ f;
    wire curN = expCur ? b : a;
    wire ok = clkOut === expOut && bOut === ({8{expOut}} & ld)
        && (md != GCGM_MODE_MUX || (sAct === expCur && sSw === expHold));

    initial begin
        forever #25 clk = ~clk;
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {expOut, expCur, expHold, pa, pb, enP, pass} = '0;
        end else begin
            if (a && !pa) pass = enP;
            case (md)
                GCGM_MODE_BUFFER: expOut = a ^ f;
                GCGM_MODE_GATE: expOut = (a && pass) ^ f;
                GCGM_MODE_MUX: begin
                    expOut = (!expHold && curN) ^ f;
                    if (!expHold && sel != expCur && !curN) expHold = 1;
                    else if (expHold && sel == expCur && !curN) expHold = 0;
                    else if (expHold && sel != expCur && !(expCur ? a : b)
                             && (expCur ? pa : pb)) begin
                        expCur = ~expCur;
                        expHold = 0;
                    end
                end
                default: expOut = f;
            endcase
            pa = a;
            pb = b;
            enP = en;
        end
    end

    task automatic bad(input string m);
        $display("BAD %0t %s", $time, m);
        miscompares++;
    endtask : bad

    always @(negedge clk) begin
        if (!rstn) runLen = 9;
        else begin
            cmp_count++;
            if (!ok) bad("outputs differ from model");
            if (clkOut !== lastOut) begin
                if (runLen < 2) bad("runt phase");
                runLen = 0;
            end
            runLen++;
            lastOut = clkOut;
        end
    end

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic setup(gcgm_mode_e m, logic fe, gcgm_src_e x, gcgm_src_e y, logic [7:0] l);
        @(negedge clk);
        rstn = 0;
        {f, ld, en, sel} = {fe, l, 2'b00};
        md = m;
        s1 = x;
        s2 = y;
        repeat (4) @(negedge clk);
        rstn = 1;
    endtask : setup

    // controls only move while the watched clock is high, never in a switch
    task automatic hi();
        int i;
        for (i = 0; i < 20 && (!curN || expHold); i++) #50;
        if (i == 20) begin
            bad("clock never high");
            test_done();
        end
    endtask : hi

    task automatic t_gate(logic fe, gcgm_src_e x);
        setup(GCGM_MODE_GATE, fe, x, GCGM_SRC_PAD, 8'h3c);
        repeat (8) begin
            #51;
            hi();
            en = ~en;
            repeat (5) @(negedge clk);
        end
        $display("gate test done");
    endtask : t_gate

    task automatic t_mux(logic fe, gcgm_src_e x, gcgm_src_e y);
        setup(GCGM_MODE_MUX, fe, x, y, 8'hff);
        repeat (6) begin
            #51;
            hi();
            sel = ~sel;
            repeat (14) @(negedge clk);
        end
        $display("mux test done");
    endtask : t_mux

    initial begin
        setup(GCGM_MODE_BUFFER, 0, GCGM_SRC_PAD, GCGM_SRC_PAD, 8'ha5);
        repeat (30) @(negedge clk);
        $display("buffer test done");
        t_gate(0, GCGM_SRC_MANAGER);
        t_gate(1, GCGM_SRC_FABRIC);
        t_mux(0, GCGM_SRC_PAD, GCGM_SRC_PAD);
        t_mux(1, GCGM_SRC_FABRIC, GCGM_SRC_FABRIC);
        setup(gcgm_mode_e'(2'd3), 0, gcgm_src_e'(2'd3), gcgm_src_e'(2'd3), 8'h00);
        repeat (20) @(negedge clk);
        $display("idle test done");
        test_done();
    end
endmodule : gcgm_top_test
